/* File: logic/dac_ctl_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the converter control
// Assumes: System clock rate given in MHz
// Notes: Definitions only
`ifndef DAC_CTL_MAP_SVH
`define DAC_CTL_MAP_SVH

// ==========================================================
// Sizes
`define CODE_W 14
`define NUM_OUT_CH 32
`define NUM_ALL_CH 33
`define OFFSET_CH_IDX 6'h20
`define CH_IDX_W 6
`define ADDR_W 8
`define ADDR_OFFSET_BIT 5
`define CODE_RESET 14'h0000

// ==========================================================
// Serial word lengths
`define SHORT_WORD_BITS 5'h0A
`define LONG_WORD_BITS 5'h18
`define BIT_CNT_W 5

// ==========================================================
// Timing
`define SYS_CLK_MHZ 250
`define GLITCH_MAX_NS 90
`define RESET_MAX_NS 200
`define ACQ_TIME_NS 16000
`define GLITCH_CYC ((`GLITCH_MAX_NS * `SYS_CLK_MHZ + 999) / 1000)
`define RESET_MAX_CYC ((`RESET_MAX_NS * `SYS_CLK_MHZ) / 1000)
`define ACQ_CYC ((`ACQ_TIME_NS * `SYS_CLK_MHZ) / 1000)
`define LOW_CNT_W 8
`define ACQ_CNT_W 12

`endif

/* File: logic/dac_ctl_pkg.sv */
// Purpose: Types shared by the converter control files
// Assumes: Map header on the include path
// Notes: Frame layout is mode first, then address, then code
`include "dac_ctl_map.svh"
`default_nettype none

package dac_ctl_pkg;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_SAMPLE_HOLD = 2'b00,
    MODE_LOAD = 2'b01,
    MODE_ACQ_READ = 2'b10,
    MODE_READ = 2'b11
  } mode_t;

  typedef enum logic {
    ACQ_IDLE = 1'b0,
    ACQ_RUN = 1'b1
  } acq_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    mode_t mode;
    logic [`ADDR_W-1:0] addr;
    logic [`CODE_W-1:0] code;
  } frame_t;

  typedef struct packed {
    logic valid;
    logic [`CH_IDX_W-1:0] chan;
    logic [`CODE_W-1:0] code;
  } update_t;

endpackage

`default_nettype wire

/* File: logic/dac_ctl_top.sv */
// Purpose: Channel code registers, offset channel and acquisition control of the converter
// Assumes: Sample input arrives already digitised on the system clock
// Notes: Readback shifting is not part of this block
`include "dac_ctl_map.svh"
`default_nettype none

module dac_ctl_top #(
  parameter int ACQ_CYC = `ACQ_CYC,
  parameter int GLITCH_CYC = `GLITCH_CYC,
  parameter int RESET_MAX_CYC = `RESET_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic track_rst_n,
  input wire logic [`CODE_W-1:0] analog_sample_input,
  output dac_ctl_pkg::update_t chan_update,
  output logic [`CODE_W-1:0] offset_channel_output,
  output logic busy_n,
  output logic route_sample_input,
  output logic [`CH_IDX_W-1:0] route_chan
);

  logic line_low;
  logic reset_pulse;
  logic track_rise;
  logic tracking;
  logic rst_all;
  logic abort_req_reg;
  logic abort_ack;
  logic ack_s1_reg;
  logic ack_s2_reg;
  dac_ctl_pkg::frame_t word_reg;
  logic done_tgl;
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_prev_reg;
  logic frame_strobe;
  dac_ctl_pkg::frame_t frame;
  logic [`CH_IDX_W-1:0] frame_chan;
  logic [`CODE_W-1:0] code_reg [0:`NUM_ALL_CH-1];
  logic [`CH_IDX_W-1:0] sel_chan_reg;
  logic pending_reg;
  dac_ctl_pkg::acq_state_t acq_state_reg;
  logic [`ACQ_CNT_W-1:0] acq_cnt_reg;
  logic acq_start;
  logic acq_done;
  logic load_hit;
  logic sample_hit;
  dac_ctl_pkg::update_t update_reg;
  logic [`CODE_W-1:0] offset_out_reg;

  // ==========================================================
  // Reset and pin classification
  low_pulse_meter #(
    .GLITCH_CYC(GLITCH_CYC),
    .RESET_MAX_CYC(RESET_MAX_CYC)
  ) u_meter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .track_rst_n(track_rst_n),
    .line_low(line_low),
    .reset_pulse(reset_pulse),
    .track_rise(track_rise),
    .tracking(tracking)
  );

  // Pin reset acts like power-on for every register below except the ack and done synchronisers
  assign rst_all = sys_rst | reset_pulse;

  // ==========================================================
  // Link abort handshake
  // Held until the link side answers, since the serial clock may be stopped
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      abort_req_reg <= 1'b1;
    end else if (ack_s2_reg) begin
      abort_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= abort_ack;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  serial_frame_rx u_rx (
    .sclk(sclk),
    .sync_n(sync_n),
    .din(din),
    .abort_req(abort_req_reg),
    .abort_ack(abort_ack),
    .word_reg(word_reg),
    .done_tgl_reg(done_tgl)
  );

  // ==========================================================
  // Word crossing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      done_s1_reg <= done_tgl;
      done_s2_reg <= done_s1_reg;
      done_prev_reg <= done_s2_reg;
    end
  end

  // Word register is stable for many link bits after the toggle moves
  // Link clear flips the toggle after the ack; masked until the ack falls again
  assign frame_strobe = (done_s2_reg != done_prev_reg) && !abort_req_reg
    && !ack_s2_reg;
  assign frame = word_reg;
  assign frame_chan = frame.addr[`ADDR_OFFSET_BIT] ? `OFFSET_CH_IDX
    : {1'b0, frame.addr[4:0]};

  assign load_hit = frame_strobe && frame.mode == dac_ctl_pkg::MODE_LOAD;
  assign sample_hit = frame_strobe && (frame.mode == dac_ctl_pkg::MODE_SAMPLE_HOLD
    || frame.mode == dac_ctl_pkg::MODE_ACQ_READ);

  // ==========================================================
  // Acquisition control
  // Addressing while busy is dropped; the running capture keeps its channel
  assign acq_start = acq_state_reg == dac_ctl_pkg::ACQ_IDLE
    && ((sample_hit && !line_low) || (pending_reg && track_rise));
  assign acq_done = acq_state_reg == dac_ctl_pkg::ACQ_RUN
    && acq_cnt_reg == ACQ_CYC[`ACQ_CNT_W-1:0] - 12'h001;

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      sel_chan_reg <= 6'h00;
      pending_reg <= 1'b0;
    end else if (acq_state_reg == dac_ctl_pkg::ACQ_IDLE && sample_hit) begin
      sel_chan_reg <= frame_chan;
      pending_reg <= line_low;
    end else if (acq_start) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      acq_state_reg <= dac_ctl_pkg::ACQ_IDLE;
      acq_cnt_reg <= 12'h000;
    end else begin
      unique case (acq_state_reg)
        dac_ctl_pkg::ACQ_IDLE: begin
          acq_cnt_reg <= 12'h000;
          if (acq_start) begin
            acq_state_reg <= dac_ctl_pkg::ACQ_RUN;
          end
        end
        dac_ctl_pkg::ACQ_RUN: begin
          acq_cnt_reg <= acq_cnt_reg + 12'h001;
          if (acq_done) begin
            acq_state_reg <= dac_ctl_pkg::ACQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      busy_n <= 1'b1;
    end else if (acq_start) begin
      busy_n <= 1'b0;
    end else if (acq_done) begin
      busy_n <= 1'b1;
    end
  end

  // ==========================================================
  // Channel code registers
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      for (int i = 0; i < `NUM_ALL_CH; i++) begin
        code_reg[i] <= `CODE_RESET;
      end
    end else if (acq_done) begin
      code_reg[sel_chan_reg] <= analog_sample_input;
    end else if (load_hit) begin
      code_reg[frame_chan] <= frame.code;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      update_reg <= '0;
    end else if (acq_done) begin
      update_reg <= '{valid: 1'b1, chan: sel_chan_reg, code: analog_sample_input};
    end else if (load_hit) begin
      update_reg <= '{valid: 1'b1, chan: frame_chan, code: frame.code};
    end else begin
      update_reg <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      offset_out_reg <= `CODE_RESET;
    end else if (acq_done && sel_chan_reg == `OFFSET_CH_IDX) begin
      offset_out_reg <= analog_sample_input;
    end else if (!acq_done && load_hit && frame_chan == `OFFSET_CH_IDX) begin
      offset_out_reg <= frame.code;
    end
  end

  // ==========================================================
  // Outputs
  assign chan_update = update_reg;
  assign offset_channel_output = offset_out_reg;
  // Sample input also drives the buffer while the code is being acquired
  assign route_sample_input = tracking || acq_state_reg == dac_ctl_pkg::ACQ_RUN;
  assign route_chan = sel_chan_reg;

endmodule

`default_nettype wire

/* File: logic/low_pulse_meter.sv */
// Purpose: Times low pulses on the track and reset pin
// Assumes: Pin is asynchronous to the system clock
// Notes: Width counter saturates, so long lows never wrap into the reset window
`include "dac_ctl_map.svh"
`default_nettype none

module low_pulse_meter #(
  parameter int GLITCH_CYC = `GLITCH_CYC,
  parameter int RESET_MAX_CYC = `RESET_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic track_rst_n,
  output logic line_low,
  output logic reset_pulse,
  output logic track_rise,
  output logic tracking
);

  logic s1_reg;
  logic s2_reg;
  logic prev_reg;
  logic [`LOW_CNT_W-1:0] cnt_reg;
  logic rst_p_reg;
  logic rise_reg;

  // ==========================================================
  // Synchroniser
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      s1_reg <= track_rst_n;
      s2_reg <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  // ==========================================================
  // Width count and classification
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= 8'h00;
    end else if (s2_reg) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hFF) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_p_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      // Short pulses fall through both tests and do nothing
      rst_p_reg <= s2_reg && !prev_reg && cnt_reg >= GLITCH_CYC[`LOW_CNT_W-1:0]
        && cnt_reg <= RESET_MAX_CYC[`LOW_CNT_W-1:0];
      rise_reg <= s2_reg && !prev_reg
        && cnt_reg > RESET_MAX_CYC[`LOW_CNT_W-1:0];
    end
  end

  assign line_low = !s2_reg;
  assign reset_pulse = rst_p_reg;
  assign track_rise = rise_reg;
  assign tracking = !s2_reg && cnt_reg > RESET_MAX_CYC[`LOW_CNT_W-1:0];

endmodule

`default_nettype wire

/* File: logic/serial_frame_rx.sv */
// Purpose: Serial word receiver on the link clock
// Assumes: Data and frame select are stable at the falling serial clock edge
// Notes: Word is held until the next word completes
`include "dac_ctl_map.svh"
`default_nettype none

module serial_frame_rx (
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic abort_req,
  output logic abort_ack,
  output dac_ctl_pkg::frame_t word_reg,
  output logic done_tgl_reg
);

  logic abort_s1_reg;
  logic abort_s2_reg;
  logic active_reg;
  logic halted_reg;
  logic [`BIT_CNT_W-1:0] cnt_reg;
  logic [`BIT_CNT_W-1:0] cnt_next;
  logic [1:0] mode_reg;
  logic [`LONG_WORD_BITS-1:0] shift_reg;
  logic [`LONG_WORD_BITS-1:0] shift_next;
  logic [`BIT_CNT_W-1:0] need;

  // ==========================================================
  // Abort crossing
  always_ff @(negedge sclk) begin
    abort_s1_reg <= abort_req;
    abort_s2_reg <= abort_s1_reg;
  end
  assign abort_ack = abort_s2_reg;

  // ==========================================================
  // Bit counter and shifter
  assign cnt_next = cnt_reg + 5'h01;
  assign shift_next = {shift_reg[`LONG_WORD_BITS-2:0], din};
  assign need = (mode_reg == dac_ctl_pkg::MODE_LOAD) ? `LONG_WORD_BITS : `SHORT_WORD_BITS;

  always_ff @(negedge sclk) begin
    if (abort_s2_reg) begin
      active_reg <= 1'b0;
      cnt_reg <= 5'h00;
      done_tgl_reg <= 1'b0;
    end else if (!active_reg && !halted_reg && !sync_n) begin
      active_reg <= 1'b1;
      cnt_reg <= 5'h01;
      shift_reg <= shift_next;
      mode_reg <= {din, 1'b0};
    end else if (active_reg) begin
      // Frame select is not looked at until the word is complete
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      if (cnt_reg == 5'h01) begin
        mode_reg[0] <= din;
      end
      if (cnt_reg >= 5'h02 && cnt_next == need) begin
        active_reg <= 1'b0;
        done_tgl_reg <= ~done_tgl_reg;
        if (need == `LONG_WORD_BITS) begin
          word_reg <= shift_next;
        end else begin
          word_reg <= {shift_next[`SHORT_WORD_BITS-1:0], `CODE_RESET};
        end
      end
    end
  end

  // Extra clocks are ignored until the frame select is released
  // Cleared by the frame select itself, since the serial clock may stand still
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      halted_reg <= 1'b0;
    end else if (abort_s2_reg) begin
      halted_reg <= 1'b0;
    end else if (active_reg && cnt_reg >= 5'h02 && cnt_next == need) begin
      halted_reg <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: verif/dac_ctl_checker.sv */
// Purpose: Port-level checks of the converter control
// Assumes: Single system clock domain at the ports
// Notes: Bound to dac_ctl_top below
`include "dac_ctl_map.svh"
`default_nettype none

module dac_ctl_checker #(
  parameter int ACQ_CYC = `ACQ_CYC,
  parameter int RESET_MAX_CYC = `RESET_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic track_rst_n,
  input wire logic [`CODE_W-1:0] analog_sample_input,
  input wire dac_ctl_pkg::update_t chan_update,
  input wire logic [`CODE_W-1:0] offset_channel_output,
  input wire logic busy_n,
  input wire logic route_sample_input,
  input wire logic [`CH_IDX_W-1:0] route_chan
);
  // ==========================================================
  // Helper counters
  logic [11:0] busy_lo_reg;
  logic [7:0] pin_lo_reg;

  default clocking @(posedge clk_sys); endclocking

  always_ff @(posedge clk_sys) begin
    if (sys_rst || busy_n) busy_lo_reg <= 12'h000;
    else busy_lo_reg <= busy_lo_reg + 12'h001;
  end

  // Saturates so a long low never wraps back under the track bound
  always_ff @(posedge clk_sys) begin
    if (track_rst_n) pin_lo_reg <= 8'h00;
    else if (pin_lo_reg != 8'hFF) pin_lo_reg <= pin_lo_reg + 8'h01;
  end

  // ==========================================================
  // Assertions
  busy_len_a: assert property (disable iff (sys_rst)
    $rose(busy_n) && chan_update.valid |-> busy_lo_reg == ACQ_CYC)
    else $error("busy low time wrong");
  busy_route_a: assert property (disable iff (sys_rst)
    !busy_n |-> route_sample_input) else $error("acquiring without routing");
  capture_code_a: assert property (disable iff (sys_rst)
    $rose(busy_n) && chan_update.valid |-> chan_update.code == $past(analog_sample_input)
    && chan_update.chan == route_chan) else $error("captured code wrong");
  offset_follow_a: assert property (disable iff (sys_rst)
    chan_update.valid && chan_update.chan == 6'h20
    |-> ##[0:1] offset_channel_output == $past(chan_update.code, 1) ||
    offset_channel_output == chan_update.code) else $error("offset output stale");
  valid_pulse_a: assert property (disable iff (sys_rst)
    chan_update.valid |=> !chan_update.valid) else $error("update not a pulse");
  chan_range_a: assert property (disable iff (sys_rst)
    chan_update.valid |-> chan_update.chan <= 6'h20) else $error("channel out of range");
  reset_clear_a: assert property (
    sys_rst ##1 sys_rst |-> busy_n && !route_sample_input && !chan_update.valid
    && offset_channel_output == 14'h0000) else $error("reset state wrong");
  track_route_a: assert property (disable iff (sys_rst)
    pin_lo_reg > RESET_MAX_CYC + 8 |-> route_sample_input) else $error("not tracking");
endmodule

bind dac_ctl_top dac_ctl_checker #(.ACQ_CYC(ACQ_CYC), .RESET_MAX_CYC(RESET_MAX_CYC))
  i_dac_ctl_checker (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .sync_n(sync_n),
  .din(din), .track_rst_n(track_rst_n), .analog_sample_input(analog_sample_input),
  .chan_update(chan_update), .offset_channel_output(offset_channel_output),
  .busy_n(busy_n), .route_sample_input(route_sample_input), .route_chan(route_chan));

`default_nettype wire

/* File: verif/host_serial_model.sv */
// Purpose: Host side of the three-wire serial port
// Assumes: 125 ns serial clock, idle high
// Notes: Clock stands still between frames except while idle_edges runs
`default_nettype none

module host_serial_model (
  output logic sclk,
  output logic sync_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Frames
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b1;
  end

  task automatic idle_edges(input int n);
    repeat (n) begin
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
  endtask

  // Mode bits lead, then address, then code, MSB first
  task automatic send(input dac_ctl_pkg::frame_t w, input int nbits);
    logic [23:0] bits;
    bits = w;
    #1.3 sync_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      din = bits[23-i];
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
    sync_n = 1'b1;
    // Pull-up on the data line once released
    din = 1'b1;
    #500;
  endtask
endmodule

`default_nettype wire

/* File: verif/multichannel_dac_load_and_reset_bench.sv */
// Purpose: Self-checking bench of the converter control
// Assumes: Short acquisition count for run time
// Notes: Frames come from the host model
`include "dac_ctl_map.svh"
`default_nettype none

module multichannel_dac_load_and_reset_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ACQ = 20;
  logic clk_sys, sys_rst, sclk, sync_n, din, track_rst_n, busy_n, route_sample_input;
  logic [`CODE_W-1:0] analog_sample_input, offset_channel_output;
  logic [`CH_IDX_W-1:0] route_chan;
  dac_ctl_pkg::update_t chan_update, u;
  int err_total = 0;
  int n_compared = 0;

  // ==========================================================
  // Clock, instances
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  host_serial_model i_host_serial_model (.sclk(sclk), .sync_n(sync_n), .din(din));
  dac_ctl_top #(.ACQ_CYC(ACQ)) i_dac_ctl_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sclk(sclk), .sync_n(sync_n), .din(din), .track_rst_n(track_rst_n),
    .analog_sample_input(analog_sample_input), .chan_update(chan_update),
    .offset_channel_output(offset_channel_output), .busy_n(busy_n),
    .route_sample_input(route_sample_input), .route_chan(route_chan));

  // ==========================================================
  // Shared tasks
  task automatic cmp_val(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic pin_low(input int n);
    @(posedge clk_sys) track_rst_n <= 1'b0;
    cyc(n);
    track_rst_n <= 1'b1;
  endtask

  // Bounded wait; a miss leaves valid low for the compare to catch
  task automatic wait_upd;
    u = '0;
    for (int k = 0; k < 2000 && u.valid !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1 u = chan_update;
    end
  endtask

  task automatic xfer(input dac_ctl_pkg::mode_t m, input logic [7:0] a, input logic [13:0] c);
    fork
      i_host_serial_model.send({m, a, c}, (m == dac_ctl_pkg::MODE_LOAD) ? 24 : 10);
      wait_upd();
    join
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_load;
    xfer(dac_ctl_pkg::MODE_LOAD, 8'h03, 14'h1A5C);
    cmp_val(u, {1'b1, 6'h03, 14'h1A5C});
    xfer(dac_ctl_pkg::MODE_LOAD, 8'h1F, 14'h3FFF);
    cmp_val(u, {1'b1, 6'h1F, 14'h3FFF});
    xfer(dac_ctl_pkg::MODE_LOAD, 8'h20, 14'h2BCD);
    cmp_val(u, {1'b1, 6'h20, 14'h2BCD});
    cmp_val(offset_channel_output, 21'h02BCD);
  endtask

  task automatic t_modes;
    dac_ctl_pkg::mode_t ml[3];
    logic [13:0] last;
    ml = '{dac_ctl_pkg::MODE_READ, dac_ctl_pkg::MODE_ACQ_READ, dac_ctl_pkg::MODE_SAMPLE_HOLD};
    last = 14'h2BCD;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) analog_sample_input <= 14'h0F00 + 14'(i);
      xfer(ml[i], 8'h20, 14'h0000);
      if (i > 0) last = 14'h0F00 + 14'(i);
      cmp_val(u, (i == 0) ? 21'h0 : {1'b1, 6'h20, last});
      cmp_val(offset_channel_output, {7'h00, last});
    end
  endtask

  task automatic t_glitch;
    pin_low(10);
    cyc(10);
    cmp_val(offset_channel_output, 21'h00F02);
    cmp_flag(busy_n, 1'b1);
  endtask

  task automatic t_track;
    @(posedge clk_sys) analog_sample_input <= 14'h2222;
    track_rst_n <= 1'b0;
    cyc(60);
    cmp_flag(route_sample_input, 1'b1);
    i_host_serial_model.send({dac_ctl_pkg::MODE_SAMPLE_HOLD, 8'h07, 14'h0000}, 10);
    cmp_flag(busy_n, 1'b1);
    cmp_val(route_chan, 21'h07);
    @(posedge clk_sys) track_rst_n <= 1'b1;
    wait_upd();
    cmp_val(u, {1'b1, 6'h07, 14'h2222});
    cmp_val(offset_channel_output, 21'h00F02);
  endtask

  task automatic t_pin_reset;
    // Cut frame left hanging for the pin reset to abort
    i_host_serial_model.send({dac_ctl_pkg::MODE_LOAD, 8'h09, 14'h1111}, 5);
    pin_low(30);
    cyc(10);
    cmp_val(offset_channel_output, 21'h0);
    cmp_flag(busy_n, 1'b1);
    // Link clear needs several serial clocks before the next frame
    i_host_serial_model.idle_edges(6);
    xfer(dac_ctl_pkg::MODE_LOAD, 8'h05, 14'h0155);
    cmp_val(u, {1'b1, 6'h05, 14'h0155});
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    track_rst_n = 1'b1;
    analog_sample_input = 14'h0000;
    cyc(6);
    sys_rst <= 1'b0;
    cyc(2);
    cmp_val(offset_channel_output, 21'h0);
    cmp_flag(route_sample_input, 1'b0);
    i_host_serial_model.idle_edges(6);
    t_load();
    t_modes();
    t_glitch();
    t_track();
    t_pin_reset();
    conclude();
  end

  // Roughly five times the expected run
  initial begin
    #150000;
    err_total++;
    conclude();
  end
endmodule

`default_nettype wire
